// File: verilog/gpio_pkg.sv
package gpio_pkg;

  // Byte offsets within the slave's window
  localparam logic [7:0] P0_DATA = 8'h00;
  localparam logic [7:0] P0_DIR = 8'h04;
  localparam logic [7:0] P0_PULL = 8'h08;
  localparam logic [7:0] AIDR_LOW = 8'h0C;
  localparam logic [7:0] P1_DATA = 8'h10;
  localparam logic [7:0] P1_DIR = 8'h14;
  localparam logic [7:0] P1_PULL = 8'h18;
  localparam logic [7:0] SYS_CTRL = 8'h1C;
  // Latch readback views of the data registers
  localparam logic [7:0] P0_DATA_RMW = 8'h40;
  localparam logic [7:0] P1_DATA_RMW = 8'h50;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [23:0] PAD_ZERO = 24'h000000;

  // Control register fields
  localparam int CB_SPL = 0;
  localparam int CB_REMAP = 1;
  localparam int CB_GATE0 = 2;
  localparam int CB_NEG0 = 3;
  localparam int CB_GATE1 = 4;
  localparam int CB_NEG1 = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3F;

  // Port 0 comparator pin positions
  localparam int CMP0_POS_BIT = 0;
  localparam int CMP0_NEG_BIT = 1;
  localparam int CMP1_POS_BIT = 3;
  localparam int CMP1_NEG_BIT = 4;

  // Port 1 peripheral input pin positions
  localparam int DBG_BIT = 2;
  localparam int TRIG_BIT = 7;

  // Port 1 and port 0 pad options
  localparam logic [7:0] P1_OD_MASK = 8'h00;
  localparam logic [7:0] P1_PULL_MASK = 8'hFB;
  localparam logic [7:0] P0_OD_MASK = 8'h00;
  localparam logic [7:0] P0_PULL_MASK = 8'hFF;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pull;
  } port_regs_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_on;
  } pad_drive_s;

endpackage : gpio_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s s;
  sync_s n;

  always_comb begin
    n = s;
    n.s1 = async_in;
    n.s2 = s.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sync_out = s.s2;
endmodule : pin_sync

// File: verilog/pad_port8.sv
`timescale 1ns/100ps
module pad_port8 #(
  parameter logic [7:0] OD_MASK = 8'h00,
  parameter logic [7:0] PULL_MASK = 8'hFF
) (
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] pull,
  input wire logic [7:0] per_out,
  input wire logic [7:0] per_oe,
  input wire logic force_hiz,
  input wire logic [7:0] keep,
  input wire logic [7:0] pin_sync,
  output gpio_pkg::pad_drive_s drive,
  output logic [7:0] in_gated
);
  logic [7:0] lvl;
  logic [7:0] en;

  always_comb begin
    en = per_oe | dir;
    lvl = (per_oe & per_out) | (~per_oe & latch);
    drive.out = lvl;
    drive.oe = en & ~(OD_MASK & lvl) & {8{~force_hiz}};
    drive.pull_on = pull & PULL_MASK & ~(drive.oe & ~lvl);
    in_gated = pin_sync & ({8{~force_hiz}} | keep);
  end
endmodule : pad_port8

// File: verilog/gpio_port_pin_control.sv
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module gpio_port_pin_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic standby_mode,
  input wire logic [7:0] ext_irq_enable,
  input wire logic [7:0] port0_periph_out,
  input wire logic [7:0] port0_periph_oe,
  input wire logic [5:0] pulse_out,
  input wire logic [5:0] pulse_oe,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  output logic [7:0] port0_pullup_on,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  output logic [7:0] port1_pullup_on,
  output logic [5:0] port6_pulse_out,
  output logic [5:0] port6_pulse_oe,
  output logic [7:0] ext_irq_level,
  output logic [7:0] port0_digital_in,
  output logic debug_wire_in,
  output logic position_trigger_in,
  output logic [1:0] cmp_pos_en,
  output logic [1:0] cmp_neg_en
);
  typedef struct packed {
    gpio_pkg::port_regs_s p0;
    gpio_pkg::port_regs_s p1;
    logic [7:0] aidr;
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    gpio_pkg::pad_drive_s d0;
    gpio_pkg::pad_drive_s d1;
    logic [5:0] p6_out;
    logic [5:0] p6_oe;
    logic [7:0] irq;
    logic [7:0] dig0;
    logic dbg;
    logic trig;
    logic [1:0] cpos;
    logic [1:0] cneg;
    logic stby_prev;
    logic hiz;
  } state_s;

  state_s s;
  state_s n;

  logic [15:0] pins_sync;
  logic [7:0] sync0;
  logic [7:0] sync1;
  logic [7:0] p1_per_out;
  logic [7:0] p1_per_oe;
  logic entering;
  logic hiz_now;
  logic hold;
  logic remap;
  gpio_pkg::pad_drive_s drv0;
  gpio_pkg::pad_drive_s drv1;
  logic [7:0] gated0;
  logic [7:0] gated1;

  pin_sync #(
    .W(16)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({port1_pin_in, port0_pin_in}),
    .sync_out(pins_sync)
  );

  assign sync0 = pins_sync[7:0];
  assign sync1 = pins_sync[15:8];
  assign remap = s.ctrl[gpio_pkg::CB_REMAP];

  // Pulse outputs routed to port 1 when not remapped
  always_comb begin
    p1_per_out = {1'b0, pulse_out[5], pulse_out[4], pulse_out[1],
                  pulse_out[0], 1'b0, pulse_out[3], pulse_out[2]};
    p1_per_oe = {1'b0, pulse_oe[5], pulse_oe[4], pulse_oe[1],
                 pulse_oe[0], 1'b0, pulse_oe[3], pulse_oe[2]} & {8{~remap}};
  end

  // Pin-state choice is taken at the moment standby begins
  always_comb begin
    entering = standby_mode & ~s.stby_prev;
    hiz_now = standby_mode & (s.hiz | (entering & s.ctrl[gpio_pkg::CB_SPL]));
    hold = standby_mode & ~hiz_now;
  end

  pad_port8 #(
    .OD_MASK(gpio_pkg::P0_OD_MASK),
    .PULL_MASK(gpio_pkg::P0_PULL_MASK)
  ) u_pad0 (
    .latch(s.p0.data),
    .dir(s.p0.dir),
    .pull(s.p0.pull),
    .per_out(port0_periph_out),
    .per_oe(port0_periph_oe),
    .force_hiz(hiz_now),
    .keep(ext_irq_enable),
    .pin_sync(sync0),
    .drive(drv0),
    .in_gated(gated0)
  );

  pad_port8 #(
    .OD_MASK(gpio_pkg::P1_OD_MASK),
    .PULL_MASK(gpio_pkg::P1_PULL_MASK)
  ) u_pad1 (
    .latch(s.p1.data),
    .dir(s.p1.dir),
    .pull(s.p1.pull),
    .per_out(p1_per_out),
    .per_oe(p1_per_oe),
    .force_hiz(hiz_now),
    .keep(gpio_pkg::REG_RESET),
    .pin_sync(sync1),
    .drive(drv1),
    .in_gated(gated1)
  );

  always_comb begin
    n = s;
    n.stby_prev = standby_mode;
    n.hiz = hiz_now;
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    n.ready = 1'b1;
    // Write lands at the end of its data phase
    if (s.wr_pend) begin
      unique case (s.addr)
        gpio_pkg::P0_DATA, gpio_pkg::P0_DATA_RMW: n.p0.data = hwdata[7:0];
        gpio_pkg::P0_DIR: n.p0.dir = hwdata[7:0];
        gpio_pkg::P0_PULL: n.p0.pull = hwdata[7:0];
        gpio_pkg::AIDR_LOW: n.aidr = hwdata[7:0];
        gpio_pkg::P1_DATA, gpio_pkg::P1_DATA_RMW: n.p1.data = hwdata[7:0];
        gpio_pkg::P1_DIR: n.p1.dir = hwdata[7:0];
        gpio_pkg::P1_PULL: n.p1.pull = hwdata[7:0];
        gpio_pkg::SYS_CTRL: n.ctrl = hwdata[7:0] & gpio_pkg::CTRL_MASK;
        default: n.addr = s.addr;
      endcase
    end
    // Read data comes after one wait state
    if (s.rd_pend) begin
      unique case (s.addr)
        gpio_pkg::P0_DATA: n.rdata = {gpio_pkg::PAD_ZERO, sync0};
        gpio_pkg::P0_DATA_RMW: n.rdata = {gpio_pkg::PAD_ZERO, s.p0.data};
        gpio_pkg::P0_DIR: n.rdata = {gpio_pkg::PAD_ZERO, s.p0.dir};
        gpio_pkg::P0_PULL: n.rdata = {gpio_pkg::PAD_ZERO, s.p0.pull};
        gpio_pkg::AIDR_LOW: n.rdata = {gpio_pkg::PAD_ZERO, s.aidr};
        gpio_pkg::P1_DATA: n.rdata = {gpio_pkg::PAD_ZERO, sync1};
        gpio_pkg::P1_DATA_RMW: n.rdata = {gpio_pkg::PAD_ZERO, s.p1.data};
        gpio_pkg::P1_DIR: n.rdata = {gpio_pkg::PAD_ZERO, s.p1.dir};
        gpio_pkg::P1_PULL: n.rdata = {gpio_pkg::PAD_ZERO, s.p1.pull};
        gpio_pkg::SYS_CTRL: n.rdata = {gpio_pkg::PAD_ZERO, s.ctrl};
        default: n.rdata = {gpio_pkg::PAD_ZERO, gpio_pkg::REG_RESET};
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      n.addr = haddr[7:0];
      n.wr_pend = hwrite;
      n.rd_pend = ~hwrite;
      n.ready = hwrite;
    end
    // Pads frozen while standby holds levels
    if (!hold) begin
      n.d0 = drv0;
      n.d1 = drv1;
      n.p6_out = pulse_out;
      n.p6_oe = pulse_oe & {6{remap & ~hiz_now}};
    end
    n.irq = gated0;
    n.dig0 = gated0 & s.aidr;
    n.dbg = gated1[gpio_pkg::DBG_BIT];
    n.trig = gated1[gpio_pkg::TRIG_BIT];
    n.cpos = {~s.aidr[gpio_pkg::CMP1_POS_BIT] & ~s.ctrl[gpio_pkg::CB_GATE1],
              ~s.aidr[gpio_pkg::CMP0_POS_BIT] & ~s.ctrl[gpio_pkg::CB_GATE0]};
    n.cneg = {~s.aidr[gpio_pkg::CMP1_NEG_BIT] & ~s.ctrl[gpio_pkg::CB_GATE1]
              & ~s.ctrl[gpio_pkg::CB_NEG1],
              ~s.aidr[gpio_pkg::CMP0_NEG_BIT] & ~s.ctrl[gpio_pkg::CB_GATE0]
              & ~s.ctrl[gpio_pkg::CB_NEG0]};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign port0_pin_out = s.d0.out;
  assign port0_pin_oe = s.d0.oe;
  assign port0_pullup_on = s.d0.pull_on;
  assign port1_pin_out = s.d1.out;
  assign port1_pin_oe = s.d1.oe;
  assign port1_pullup_on = s.d1.pull_on;
  assign port6_pulse_out = s.p6_out;
  assign port6_pulse_oe = s.p6_oe;
  assign ext_irq_level = s.irq;
  assign port0_digital_in = s.dig0;
  assign debug_wire_in = s.dbg;
  assign position_trigger_in = s.trig;
  assign cmp_pos_en = s.cpos;
  assign cmp_neg_en = s.cneg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rd_addr;
    hsel && htrans == gpio_pkg::HTRANS_NONSEQ && !hwrite && hready;
  endsequence

  sequence s_wr_p1;
    hsel && htrans == gpio_pkg::HTRANS_NONSEQ && hwrite && hready
      && haddr[7:0] == gpio_pkg::P1_DATA;
  endsequence

  chk_read_wait: assert property (s_rd_addr |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  chk_p1_write: assert property (s_wr_p1 ##1 1'b1 |=> s.p1.data == $past(hwdata[7:0]))
    else $error("port 1 latch not written");

  chk_reset_dir: assert property ($rose(hresetn) |-> s.p0.dir == 8'h00 && s.aidr == 8'h00)
    else $error("direction not cleared by reset");

  chk_hiz_force: assert property (s.hiz |->
                                  port0_pin_oe == 8'h00 && port1_pin_oe == 8'h00
                                  && port6_pulse_oe == 6'h00)
    else $error("pins driven in forced standby");

  chk_irq_keep: assert property (s.hiz && standby_mode |=>
                                 ext_irq_level == ($past(sync0) & $past(ext_irq_enable)))
    else $error("interrupt input gating wrong");

  chk_hold_level: assert property (s.stby_prev && standby_mode && !s.hiz
                                   |=> $stable(port1_pin_out) && $stable(port1_pin_oe))
    else $error("standby level not held");

  chk_remap_p6: assert property (!standby_mode |=> port6_pulse_out == $past(pulse_out)
                                 && port6_pulse_oe == ($past(pulse_oe) & {6{$past(remap)}}))
    else $error("pulse remap wrong");

  chk_pull_low: assert property (
                                 (port0_pullup_on & port0_pin_oe & ~port0_pin_out) == 8'h00
                                 && port1_pullup_on[gpio_pkg::DBG_BIT] == 1'b0)
    else $error("pull-up on low output");

  chk_od_high: assert property (
                                (port1_pin_oe & port1_pin_out & gpio_pkg::P1_OD_MASK) == 8'h00)
    else $error("open-drain pin driven high");

  chk_cmp_neg: assert property (s.ctrl[gpio_pkg::CB_NEG0] |=> !cmp_neg_en[0])
    else $error("comparator negative input not gated");

  chk_p0_drive: assert property (!standby_mode |=>
                                 port0_pin_oe == ($past(port0_periph_oe) | $past(s.p0.dir)))
    else $error("port 0 driver enable wrong");

  chk_dig_gate: assert property (port0_digital_in == (ext_irq_level & $past(s.aidr)))
    else $error("digital input gating wrong");
endmodule : gpio_port_pin_control

// File: test/pin_model.sv
`timescale 1ns/100ps
module pin_model (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  logic [7:0] flt_r = 8'h55;

  // Open pins toggle so a stale level is never read back
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext[i];
      else if (pull[i]) pin[i] = 1'b1;
      else pin[i] = flt_r[i];
    end
  end
endmodule : pin_model

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, standby_mode = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, debug_wire_in, position_trigger_in;
  logic [7:0] ext_irq_enable = 8'h00, port0_periph_out = 8'h00, port0_periph_oe = 8'h00;
  logic [5:0] pulse_out = 6'h00, pulse_oe = 6'h00, port6_pulse_out, port6_pulse_oe;
  logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_on, port1_pin_in;
  logic [7:0] port1_pin_out, port1_pin_oe, port1_pullup_on, ext_irq_level, port0_digital_in;
  logic [1:0] cmp_pos_en, cmp_neg_en;
  logic [7:0] p0_ext = 8'hFF, p0_ext_en = 8'hFF, p1_ext = 8'h3C, p1_ext_en = 8'hFF;
  logic [7:0] rst_adr[7];
  logic [7:0] cmp_ctl[3], cmp_aid[3];
  logic [3:0] cmp_exp[3];
  int err_count = 0, check_count = 0;

  always #12.5 hclk = ~hclk;

  gpio_port_pin_control i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .standby_mode, .ext_irq_enable, .port0_periph_out,
    .port0_periph_oe, .pulse_out, .pulse_oe, .port0_pin_in, .port0_pin_out, .port0_pin_oe,
    .port0_pullup_on, .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pullup_on,
    .port6_pulse_out, .port6_pulse_oe, .ext_irq_level, .port0_digital_in, .debug_wire_in,
    .position_trigger_in, .cmp_pos_en, .cmp_neg_en
  );

  pin_model i_pins0 (.clk(hclk), .out(port0_pin_out), .oe(port0_pin_oe),
    .pull(port0_pullup_on), .ext(p0_ext), .ext_en(p0_ext_en), .pin(port0_pin_in));
  pin_model i_pins1 (.clk(hclk), .out(port1_pin_out), .oe(port1_pin_oe),
    .pull(port1_pullup_on), .ext(p1_ext), .ext_en(p1_ext_en), .pin(port1_pin_in));

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= gpio_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(nm, {24'h000000, e}, x);
  endtask : rdc

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial begin
    rst_adr = '{gpio_pkg::P0_DIR, gpio_pkg::P0_PULL, gpio_pkg::AIDR_LOW, gpio_pkg::P1_DIR,
                gpio_pkg::P1_PULL, gpio_pkg::SYS_CTRL, 8'h30};
    cmp_ctl = '{8'h24, 8'h08, 8'h00};
    cmp_aid = '{8'h00, 8'h00, 8'h08};
    cmp_exp = '{4'h8, 4'hE, 4'h7};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    tick(3);
    foreach (rst_adr[i]) rdc("reset value", rst_adr[i], 8'h00);
    chk("cmp at reset", 32'hF, {28'h0, cmp_pos_en, cmp_neg_en});
    chk("digital in off", 32'h0, {24'h0, port0_digital_in});
    chk("okay resp", 32'h0, {31'h0, hresp});
    $display("test reset done");

    wr(gpio_pkg::P1_DATA, 8'hA5);
    tick(3);
    chk("p1 oe input", 32'h0, {24'h0, port1_pin_oe});
    rdc("p1 pin", gpio_pkg::P1_DATA, 8'h3C);
    rdc("p1 latch", gpio_pkg::P1_DATA_RMW, 8'hA5);
    chk("p1 periph in", 32'h2, {30'h0, debug_wire_in, position_trigger_in});
    p1_ext_en <= 8'h00;
    wr(gpio_pkg::P1_PULL, 8'hFF);
    wr(gpio_pkg::P1_DIR, 8'h0F);
    tick(3);
    chk("p1 oe", 32'h0F, {24'h0, port1_pin_oe});
    chk("p1 out", 32'hA5, {24'h0, port1_pin_out});
    chk("p1 pull", 32'hF1, {24'h0, port1_pullup_on});
    rdc("p1 pull reg", gpio_pkg::P1_PULL, 8'hFF);
    rdc("p1 pin out", gpio_pkg::P1_DATA, 8'hF5);
    wr(gpio_pkg::P1_DATA, 8'h5A);
    tick(3);
    chk("p1 out new", 32'h5A, {24'h0, port1_pin_out});
    $display("test port1 done");

    wr(gpio_pkg::P0_DIR, 8'h00);
    port0_periph_out <= 8'h05;
    port0_periph_oe <= 8'h0F;
    p0_ext_en <= 8'hF0;
    wr(gpio_pkg::P0_PULL, 8'hFF);
    tick(4);
    chk("p0 periph out", 32'h0F05, {16'h0, port0_pin_oe, port0_pin_out});
    chk("p0 pull", 32'hF5, {24'h0, port0_pullup_on});
    rdc("p0 pin", gpio_pkg::P0_DATA, 8'hF5);
    rdc("p0 latch", gpio_pkg::P0_DATA_RMW, 8'h00);
    chk("irq level", 32'hF5, {24'h0, ext_irq_level});
    wr(gpio_pkg::AIDR_LOW, 8'hFF);
    tick(3);
    chk("digital in on", 32'hF5, {24'h0, port0_digital_in});
    $display("test port0 done");

    pulse_out <= 6'b101101;
    pulse_oe <= 6'h3F;
    tick(3);
    chk("pulse p1", 32'h7B4B, {16'h0, port1_pin_oe & 8'h7B, port1_pin_out & 8'h7B});
    wr(gpio_pkg::SYS_CTRL, 8'h02);
    tick(3);
    chk("pulse p6", 32'h3F2D, {18'h0, port6_pulse_oe, 2'b00, port6_pulse_out});
    chk("p1 unmapped", 32'h0F, {24'h0, port1_pin_oe});
    pulse_oe <= 6'h00;
    $display("test pulse done");

    foreach (cmp_ctl[i]) begin
      wr(gpio_pkg::AIDR_LOW, cmp_aid[i]);
      wr(gpio_pkg::SYS_CTRL, cmp_ctl[i]);
      tick(3);
      chk("cmp en", {28'h0, cmp_exp[i]}, {28'h0, cmp_pos_en, cmp_neg_en});
    end
    $display("test comparator done");

    port0_periph_oe <= 8'h00;
    p0_ext_en <= 8'hFF;
    ext_irq_enable <= 8'h01;
    wr(gpio_pkg::SYS_CTRL, 8'h01);
    standby_mode <= 1'b1;
    tick(4);
    chk("forced hiz", 32'h0, {16'h0, port0_pin_oe, port1_pin_oe});
    chk("blocked in", 32'h4, {22'h0, ext_irq_level, debug_wire_in, position_trigger_in});
    standby_mode <= 1'b0;
    wr(gpio_pkg::SYS_CTRL, 8'h00);
    standby_mode <= 1'b1;
    wr(gpio_pkg::P1_DATA, 8'hC3);
    tick(3);
    chk("held", 32'h0F5A, {16'h0, port1_pin_oe, port1_pin_out});
    standby_mode <= 1'b0;
    tick(3);
    chk("released", 32'hC3, {24'h0, port1_pin_out});
    $display("test standby done");
    test_done();
  end

  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule : tb
